// File: rtl/uvep_host.sv
// Purpose: Host controller that reads, identifies and programs a UV EPROM.
// Assumes: Pins are driven through level shifters; vpp_en and id_hv_en switch supplies.
// Notes: Commands are taken one at a time; a request during a busy cycle is ignored.
module uvep_host import uvep_pkg::*; #(
    // Pulse length in cycles; a bench may shorten it to keep runs brief
    parameter int PULSE_LEN = PULSE_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Command port
    input wire logic cmd_valid,
    input wire uvep_op_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic supply_dip,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_fail,
    output logic [PCNT_W-1:0] rsp_pulses,
    // EPROM pins
    output logic [ADDR_W-1:0] mem_addr,
    output logic sel_n,
    output logic gate_n,
    output logic vpp_en,
    output logic id_hv_en,
    input wire logic [DATA_W-1:0] mem_data_i,
    output logic [DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_n
);
    uvep_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [PCNT_W-1:0] pulses_r;
    uvep_op_t op_r;
    logic [DATA_W-1:0] target_r;
    logic [DATA_W-1:0] data_s;
    logic dip_pend_r;
    logic verify_ok;
    logic [CNT_W-1:0] pw_cnt_r;

    uvep_sync #(.W(DATA_W)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d_in(mem_data_i),
        .d_out(data_s)
    );

    // Every bit must match the target, including the bits the target keeps at one
    assign verify_ok = (data_s == target_r);
    assign cmd_ready = (state_r == UVEP_IDLE);

    // A dip forces a fresh address cycle on the next read (an ID command clears it without one); we park the address at its complement
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dip_pend_r <= 1'b0;
        end else if (supply_dip) begin
            dip_pend_r <= 1'b1;
        end else if (state_r == UVEP_RD_SEL) begin
            dip_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= UVEP_IDLE;
            cnt_r <= '0;
            pulses_r <= '0;
            op_r <= UVEP_OP_READ;
            target_r <= ERASED_BYTE;
        end else begin
            unique case (state_r)
                UVEP_IDLE: begin
                    cnt_r <= '0;
                    if (cmd_valid) begin
                        op_r <= cmd_op;
                        target_r <= cmd_wdata;
                        pulses_r <= '0;
                        state_r <= (cmd_op == UVEP_OP_PROG) ? UVEP_PG_SETUP : UVEP_RD_SEL;
                    end
                end
                UVEP_RD_SEL: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(ACCESS_CYC - GATE_CYC)) begin
                        cnt_r <= '0;
                        state_r <= UVEP_RD_GATE;
                    end
                end
                UVEP_RD_GATE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(GATE_CYC + 2)) begin
                        cnt_r <= '0;
                        state_r <= UVEP_FLOAT;
                    end
                end
                UVEP_PG_SETUP: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(SETUP_CYC)) begin
                        cnt_r <= '0;
                        pulses_r <= pulses_r + 1'b1;
                        state_r <= UVEP_PG_PULSE;
                    end
                end
                UVEP_PG_PULSE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(PULSE_LEN - 1)) begin
                        cnt_r <= '0;
                        state_r <= UVEP_PG_RECOV;
                    end
                end
                UVEP_PG_RECOV: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(SETUP_CYC)) begin
                        cnt_r <= '0;
                        state_r <= UVEP_PG_VFY;
                    end
                end
                UVEP_PG_VFY: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(VERIFY_CYC + 2)) begin
                        cnt_r <= '0;
                        if (verify_ok || pulses_r == MAX_PULSES_V) begin
                            state_r <= UVEP_FLOAT;
                        end else begin
                            state_r <= UVEP_PG_SETUP;
                        end
                    end
                end
                UVEP_FLOAT: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(FLOAT_CYC)) begin
                        cnt_r <= '0;
                        state_r <= UVEP_IDLE;
                    end
                end
                default: state_r <= UVEP_IDLE;
            endcase
        end
    end

    // Pin drive: select pulses only in read cycles, program pulse and verify
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_n <= 1'b1;
            gate_n <= 1'b1;
            vpp_en <= 1'b0;
            id_hv_en <= 1'b0;
            mem_addr <= '0;
            mem_data_o <= ERASED_BYTE;
            mem_data_oe_n <= 1'b1;
        end else begin
            sel_n <= ~(state_r == UVEP_RD_SEL || state_r == UVEP_RD_GATE
                       || state_r == UVEP_PG_PULSE || state_r == UVEP_PG_VFY);
            gate_n <= ~(state_r == UVEP_RD_GATE || state_r == UVEP_PG_VFY);
            vpp_en <= (state_r == UVEP_PG_SETUP || state_r == UVEP_PG_PULSE
                       || state_r == UVEP_PG_RECOV) && op_r == UVEP_OP_PROG;
            id_hv_en <= (op_r == UVEP_OP_ID) && (state_r == UVEP_RD_SEL
                        || state_r == UVEP_RD_GATE);
            // Data stays driven through recovery to cover the hold time after the pulse
            mem_data_oe_n <= ~((state_r == UVEP_PG_SETUP || state_r == UVEP_PG_PULSE
                               || state_r == UVEP_PG_RECOV) && op_r == UVEP_OP_PROG);
            if (state_r == UVEP_IDLE && cmd_valid) begin
                mem_data_o <= cmd_wdata;
                if (cmd_op == UVEP_OP_ID) begin
                    mem_addr <= cmd_addr[0] ? ID_DEVICE_ADDR : ID_MAKER_ADDR;
                end else if (dip_pend_r && cmd_op == UVEP_OP_READ) begin
                    mem_addr <= ~cmd_addr;
                end else begin
                    mem_addr <= cmd_addr;
                end
            end else if (state_r == UVEP_RD_SEL && cnt_r == '0 && op_r == UVEP_OP_READ
                         && dip_pend_r) begin
                // Second transition back to the true address; access time restarts here
                mem_addr <= ~mem_addr;
            end
        end
    end

    // Answer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_fail <= 1'b0;
            rsp_pulses <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_r == UVEP_RD_GATE && cnt_r == CNT_W'(GATE_CYC + 2)) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_s;
                rsp_fail <= 1'b0;
                rsp_pulses <= '0;
            end else if (state_r == UVEP_PG_VFY && cnt_r == CNT_W'(VERIFY_CYC + 2)
                         && (verify_ok || pulses_r == MAX_PULSES_V)) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_s;
                rsp_fail <= ~verify_ok;
                rsp_pulses <= pulses_r;
            end
        end
    end

    // Length of the current program pulse, so the check needs no long delay range
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pw_cnt_r <= '0;
        end else if (sel_n || !vpp_en) begin
            pw_cnt_r <= '0;
        end else begin
            pw_cnt_r <= pw_cnt_r + 1'b1;
        end
    end

    // Checks
    a_gate_needs_sel: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!gate_n && !vpp_en) |-> !sel_n) else $error("gate low without select");
    a_vpp_gate_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        vpp_en |-> gate_n) else $error("gate low during program voltage");
    a_pulse_bounded: assert property (@(posedge core_clk) disable iff (sys_rst)
        pw_cnt_r <= CNT_W'(PULSE_LEN)) else $error("program pulse not ended");
    a_pulse_width: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($rose(sel_n) && $past(vpp_en)) |-> pw_cnt_r == CNT_W'(PULSE_LEN))
        else $error("program pulse length wrong");
    a_pulse_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
        pulses_r <= MAX_PULSES_V) else $error("too many pulses");
    a_data_in_prog: assert property (@(posedge core_clk) disable iff (sys_rst)
        (vpp_en && !sel_n) |-> !mem_data_oe_n) else $error("data not driven");
    a_no_drive_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        !gate_n |-> mem_data_oe_n) else $error("bus contention");
    a_fail_at_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rsp_valid && rsp_fail) |-> rsp_pulses == MAX_PULSES_V)
        else $error("failure before limit");
    a_id_addr_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        id_hv_en |-> mem_addr[ADDR_W-1:1] == '0) else $error("id address bits");
    a_standby_float: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == UVEP_IDLE) |=> ##1 (sel_n || !cmd_ready)) else $error("no standby");
    c_read: cover property (@(posedge core_clk) rsp_valid && !rsp_fail && rsp_pulses == '0);
    c_prog_ok: cover property (@(posedge core_clk) rsp_valid && !rsp_fail && rsp_pulses != '0);
    c_prog_fail: cover property (@(posedge core_clk) rsp_valid && rsp_fail);
endmodule

// File: rtl/uvep_pkg.sv
// Purpose: Shared constants for the EPROM host controller.
// Assumes: core_clk at 125 MHz.
// Notes: Times are kept in their own units; cycle counts derive from them.
package uvep_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // Read timing (ns); device speed grade is a plain default
    localparam int ACCESS_NS = 450;
    localparam int GATE_NS = 150;
    localparam int FLOAT_NS = 60;
    // Program timing
    localparam int PULSE_US = 100;
    localparam int SETUP_US = 1;
    localparam int VERIFY_NS = 250;
    localparam int MAX_PULSES = 25;
    localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int GATE_CYC = (GATE_NS * CLK_MHZ + 999) / 1000;
    localparam int FLOAT_CYC = (FLOAT_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int VERIFY_CYC = (VERIFY_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;
    localparam int PCNT_W = 5;
    localparam logic [PCNT_W-1:0] MAX_PULSES_V = PCNT_W'(MAX_PULSES);
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    localparam logic [ADDR_W-1:0] ID_DEVICE_ADDR = 12'h001;
    localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 12'h000;
    typedef enum logic [3:0] {
        UVEP_IDLE = 4'h0,
        UVEP_RD_SEL = 4'h1,
        UVEP_RD_GATE = 4'h2,
        UVEP_PG_SETUP = 4'h3,
        UVEP_PG_PULSE = 4'h4,
        UVEP_PG_RECOV = 4'h5,
        UVEP_PG_VFY = 4'h6,
        UVEP_FLOAT = 4'h7
    } uvep_state_t;
    typedef enum logic [1:0] {
        UVEP_OP_READ = 2'h0,
        UVEP_OP_PROG = 2'h1,
        UVEP_OP_ID = 2'h2
    } uvep_op_t;
endpackage

// File: rtl/uvep_sync.sv
// Purpose: Two-flop synchroniser for the data pins.
// Assumes: Input is asynchronous to core_clk.
// Notes: Only the second stage is visible.
module uvep_sync import uvep_pkg::*; #(
    parameter int W = DATA_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] d_out
);
    logic [W-1:0] meta_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            d_out <= '0;
        end else begin
            meta_r <= d_in;
            d_out <= meta_r;
        end
    end
endmodule

// File: verification/test_uvep_host.sv
// Purpose: Self-checking bench for the memory host controller.
// Assumes: Model answers within the cycle delays of the package.
// Notes: Program pulses are shortened by a parameter so the 25-pulse case stays brief.
module test_uvep_host import uvep_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [DATA_W-1:0] MK = 8'h5c;
    localparam logic [DATA_W-1:0] DV = 8'h3a;
    // Short program pulse keeps the failing case within the cycle budget
    localparam int PULSE_SIM = 500;
    logic core_clk, sys_rst, cmd_valid, supply_dip, cmd_ready, rsp_valid, rsp_fail;
    uvep_op_t cmd_op;
    logic [ADDR_W-1:0] cmd_addr, mem_addr;
    logic [DATA_W-1:0] cmd_wdata, rsp_rdata, mem_data_i, mem_data_o, dev_q, r_data;
    logic [PCNT_W-1:0] rsp_pulses, need, r_pulses;
    logic sel_n, gate_n, vpp_en, id_hv_en, mem_data_oe_n, fault, r_fail;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    assign mem_data_i = (mem_data_oe_n === 1'b0) ? mem_data_o : dev_q;
    uvep_host #(.PULSE_LEN(PULSE_SIM)) i_uvep_host (.core_clk(core_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .supply_dip(supply_dip),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_fail(rsp_fail), .rsp_pulses(rsp_pulses), .mem_addr(mem_addr), .sel_n(sel_n),
        .gate_n(gate_n), .vpp_en(vpp_en), .id_hv_en(id_hv_en), .mem_data_i(mem_data_i),
        .mem_data_o(mem_data_o), .mem_data_oe_n(mem_data_oe_n));
    uvep_eprom_model #(.MAKER_ID(MK), .DEVICE_ID(DV), .PULSE_LEN(PULSE_SIM))
        i_uvep_eprom_model (
        .core_clk(core_clk), .mem_addr(mem_addr), .sel_n(sel_n), .gate_n(gate_n),
        .vpp_en(vpp_en), .id_hv_en(id_hv_en), .host_oe_n(mem_data_oe_n),
        .supply_dip(supply_dip), .need(need), .bus(mem_data_i), .dev_q(dev_q), .fault(fault));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check_byte(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_cnt(input logic [PCNT_W-1:0] exp, input logic [PCNT_W-1:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // Request held until the edge that takes it, then the answer is awaited
    task automatic run(input uvep_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        n = 0;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        n = 0;
        @(negedge core_clk);
        while (rsp_valid !== 1'b1 && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
        check_bit(1'b1, rsp_valid);
        r_data = rsp_rdata;
        r_fail = rsp_fail;
        r_pulses = rsp_pulses;
    endtask
    task automatic t_erased();
        run(UVEP_OP_READ, 12'h123, 8'h00);
        check_byte(ERASED_BYTE, r_data);
        check_cnt(5'h00, r_pulses);
        $display("test erased done");
    endtask
    task automatic t_program();
        need <= 5'h01;
        run(UVEP_OP_PROG, 12'h123, 8'ha5);
        check_bit(1'b0, r_fail);
        check_cnt(5'h01, r_pulses);
        check_byte(8'ha5, r_data);
        run(UVEP_OP_READ, 12'h123, 8'h00);
        check_byte(8'ha5, r_data);
        run(UVEP_OP_READ, 12'h124, 8'h00);
        check_byte(ERASED_BYTE, r_data);
        $display("test program done");
    endtask
    task automatic t_slow();
        need <= 5'h03;
        run(UVEP_OP_PROG, 12'h7ff, 8'h3c);
        check_bit(1'b0, r_fail);
        check_cnt(5'h03, r_pulses);
        check_byte(8'h3c, r_data);
        $display("test slow done");
    endtask
    task automatic t_fail();
        need <= 5'h01;
        run(UVEP_OP_PROG, 12'h123, 8'h5a);
        check_bit(1'b1, r_fail);
        check_cnt(MAX_PULSES_V, r_pulses);
        run(UVEP_OP_READ, 12'h123, 8'h00);
        check_byte(8'h00, r_data);
        $display("test fail done");
    endtask
    task automatic t_ident();
        run(UVEP_OP_ID, ID_MAKER_ADDR, 8'h00);
        check_byte(MK, r_data);
        run(UVEP_OP_ID, ID_DEVICE_ADDR, 8'h00);
        check_byte(DV, r_data);
        run(UVEP_OP_READ, 12'h000, 8'h00);
        check_byte(ERASED_BYTE, r_data);
        $display("test ident done");
    endtask
    task automatic t_dip();
        run(UVEP_OP_READ, 12'h7ff, 8'h00);
        check_byte(8'h3c, r_data);
        @(posedge core_clk);
        supply_dip <= 1'b1;
        @(posedge core_clk);
        supply_dip <= 1'b0;
        // Same address again: only the forced transition makes the data valid
        run(UVEP_OP_READ, 12'h7ff, 8'h00);
        check_byte(8'h3c, r_data);
        $display("test dip done");
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        // Ceiling well above the whole run, the 25-pulse failing case included
        if (cyc == 40000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = UVEP_OP_READ;
        cmd_addr = '0;
        cmd_wdata = '0;
        supply_dip = 1'b0;
        need = 5'h01;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_erased();
        t_program();
        t_slow();
        t_ident();
        t_dip();
        t_fail();
        check_bit(1'b0, fault);
        print_verdict();
    end
endmodule

// File: verification/uvep_eprom_model.sv
// Purpose: Pin-level model of the erasable memory behind the host controller.
// Assumes: Pins sampled on core_clk; delays kept as whole cycles.
// Notes: Undriven or not-yet-valid data shows a pattern that flips every cycle.
module uvep_eprom_model import uvep_pkg::*; #(
    // Identity bytes are arbitrary values
    parameter logic [DATA_W-1:0] MAKER_ID = 8'h5c,
    parameter logic [DATA_W-1:0] DEVICE_ID = 8'h3a,
    // Expected program pulse length in cycles
    parameter int PULSE_LEN = PULSE_CYC
) (
    // Clock
    input wire logic core_clk,
    // Control pins
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic sel_n,
    input wire logic gate_n,
    input wire logic vpp_en,
    input wire logic id_hv_en,
    input wire logic host_oe_n,
    // Supply and cell behaviour
    input wire logic supply_dip,
    input wire logic [PCNT_W-1:0] need,
    // Data pins
    input wire logic [DATA_W-1:0] bus,
    output logic [DATA_W-1:0] dev_q,
    output logic fault
);
    logic [DATA_W-1:0] mem [1<<ADDR_W];
    logic [PCNT_W-1:0] hits [1<<ADDR_W];
    logic [DATA_W-1:0] junk = 8'h55;
    logic [ADDR_W-1:0] a_q = '0;
    logic vfy = 1'b0;
    logic stale = 1'b0;
    logic sel_q = 1'b1;
    int t_sel = 0;
    int t_gate = 0;
    int t_addr = 0;
    int t_pw = 0;
    logic drive;
    logic ok;
    logic id_ok;
    initial begin
        fault = 1'b0;
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] = ERASED_BYTE;
            hits[i] = '0;
        end
    end
    assign drive = !sel_n && !gate_n && !vpp_en;
    // Verify reads use the shorter select delay
    assign ok = t_sel + 1 >= (vfy ? VERIFY_CYC : ACCESS_CYC) && t_gate + 1 >= GATE_CYC
        && t_addr + 1 >= (vfy ? VERIFY_CYC : ACCESS_CYC) && !stale;
    assign id_ok = {mem_addr[11:10], mem_addr[8:1]} == '0;
    always @* begin
        dev_q = junk;
        if (drive && ok && !id_hv_en) dev_q = mem[mem_addr];
        if (drive && ok && id_hv_en && id_ok) dev_q = mem_addr[0] ? DEVICE_ID : MAKER_ID;
    end
    always @(posedge core_clk) begin
        junk <= ~dev_q;
        sel_q <= sel_n;
        t_sel <= sel_n ? 0 : t_sel + 1;
        t_gate <= gate_n ? 0 : t_gate + 1;
        a_q <= mem_addr;
        t_addr <= (mem_addr != a_q) ? 0 : t_addr + 1;
        if (supply_dip) stale <= 1'b1;
        else if (mem_addr != a_q) stale <= 1'b0;
        if (drive && !host_oe_n) fault <= 1'b1;
        if (!sel_n && vpp_en) t_pw <= t_pw + 1;
        if (sel_n && !sel_q && !vpp_en) vfy <= 1'b0;
        if (sel_n && t_pw != 0) begin
            t_pw <= 0;
            vfy <= 1'b1;
            // Pulses outside 95..105 percent of PULSE_LEN cycles or with undriven data are flagged
            if (t_pw < PULSE_LEN * 95 / 100 || t_pw > PULSE_LEN * 105 / 100 || host_oe_n) begin
                fault <= 1'b1;
            end
            hits[mem_addr] <= hits[mem_addr] + 5'h01;
            if (hits[mem_addr] + 5'h01 >= need) mem[mem_addr] <= mem[mem_addr] & bus;
        end
    end
endmodule
